// >>> design/vipt_defs.svh
`ifndef VIPT_DEFS_SVH
`define VIPT_DEFS_SVH

// Table geometry
`define VIPT_NUM_VEC 47
`define VIPT_VEC_W 6
`define VIPT_ADDR_W 19
`define VIPT_VBA_W 19
`define VIPT_VBA_RST 19'h0_0000
`define VIPT_LVL_W 2
`define VIPT_ENTRY_SHIFT 1

// Fixed core exceptions
`define VIPT_V_ILLEGAL 6'h02
`define VIPT_V_SWI3 6'h03
`define VIPT_V_STACK_OVF 6'h04
`define VIPT_V_MISALIGN 6'h05
// Debug port
`define VIPT_V_DBG_STEP 6'h06
`define VIPT_V_DBG_BKPT0 6'h07
`define VIPT_V_DBG_TRACE 6'h09
`define VIPT_V_DBG_TX_EMPTY 6'h0A
`define VIPT_V_DBG_RX_FULL 6'h0B
// Software and external requests
`define VIPT_V_SWI2 6'h0E
`define VIPT_V_SWI1 6'h0F
`define VIPT_V_SWI0 6'h10
`define VIPT_V_EXT_A 6'h11
`define VIPT_V_EXT_B 6'h12
// Power, clock, flash
`define VIPT_V_LVD 6'h14
`define VIPT_V_PLL 6'h15
`define VIPT_V_FLASH_ERR 6'h16
`define VIPT_V_FLASH_DONE 6'h17
`define VIPT_V_FLASH_EMPTY 6'h18
// CAN, GPIO, SPI, serial bases
`define VIPT_V_CAN_BASE 6'h1A
`define VIPT_V_GPIO_BASE 6'h1E
`define VIPT_V_SPI1_BASE 6'h26
`define VIPT_V_SPI0_BASE 6'h28
`define VIPT_V_ASU1_TX_EMPTY 6'h2A
`define VIPT_V_ASU1_TX_IDLE 6'h2B
`define VIPT_V_ASU1_RX_ERR 6'h2D
`define VIPT_V_ASU1_RX_FULL 6'h2E

// Level encodings
`define VIPT_LVL_0 2'h0
`define VIPT_LVL_1 2'h1
`define VIPT_LVL_2 2'h2
`define VIPT_LVL_3 2'h3

`endif

// >>> design/vipt_pkg.sv
`default_nettype none
package vipt_pkg;
  // Core exception requests
  typedef struct packed {
    logic illegal;
    logic swi3;
    logic stack_ovf;
    logic misalign;
    logic swi2;
    logic swi1;
    logic swi0;
  } vipt_core_s;

  // Debug port requests with their levels
  typedef struct packed {
    logic [4:0] req;
    logic [4:0][1:0] lvl;
  } vipt_dbg_s;

  // Peripheral requests: ext A,B, lvd, pll, flash x3, can x4, gpio F..A x6,
  // spi x4 (spi1 rx,tx, spi0 rx,tx), async serial x4 (tx empty, idle, rx err, full)
  typedef struct packed {
    logic [24:0] req;
    logic [24:0][1:0] lvl;
  } vipt_periph_s;

  // Answer to the core
  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [5:0] vector;
    logic [18:0] address;
  } vipt_grant_s;

  // Registered state of the top
  typedef struct packed {
    vipt_grant_s grant;
  } vipt_state_s;
endpackage : vipt_pkg
`default_nettype wire

// >>> design/vipt_resolve.sv
`timescale 1ns/1ps
`default_nettype none
`include "vipt_defs.svh"

// Picks highest level, then lowest vector, over a flat request table
module vipt_resolve #(
  parameter int NUM_VEC = `VIPT_NUM_VEC
) (
  // Request table
  input wire logic [NUM_VEC-1:0] req,
  input wire logic [NUM_VEC-1:0][1:0] lvl,
  // Winner
  output logic found,
  output logic [1:0] win_lvl,
  output logic [5:0] win_vec
);
  // Scan from highest index down so the lowest vector wins ties
  always_comb begin
    found = 1'b0;
    win_lvl = `VIPT_LVL_0;
    win_vec = 6'h00;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req[i] && (!found || lvl[i] >= win_lvl)) begin
        found = 1'b1;
        win_lvl = lvl[i];
        win_vec = 6'(i);
      end
    end
  end
endmodule : vipt_resolve
`default_nettype wire

// >>> design/vipt_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "vipt_defs.svh"

module vipt_table (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Vector base register
  input wire logic [18:0] vector_base_register,
  // Request sources
  input wire vipt_pkg::vipt_core_s core_req,
  input wire vipt_pkg::vipt_dbg_s dbg_req,
  input wire vipt_pkg::vipt_periph_s per_req,
  // Selected interrupt to the core
  output var vipt_pkg::vipt_grant_s grant
);
  import vipt_pkg::*;

  vipt_state_s state_reg;
  vipt_state_s state_next;
  logic [`VIPT_NUM_VEC-1:0] req_vec;
  logic [`VIPT_NUM_VEC-1:0][1:0] lvl_vec;
  logic found;
  logic [1:0] win_lvl;
  logic [5:0] win_vec;

  // Clamp a requested level into the range lo..hi
  function automatic logic [1:0] clamp_lvl(input logic [1:0] l, input logic [1:0] lo,
                                           input logic [1:0] hi);
    if (l < lo) begin
      return lo;
    end else if (l > hi) begin
      return hi;
    end
    return l;
  endfunction : clamp_lvl

  // Base plus two words per entry
  function automatic logic [18:0] vec_addr(input logic [18:0] base, input logic [5:0] v);
    return 19'(base + (19'(v) << `VIPT_ENTRY_SHIFT));
  endfunction : vec_addr

  // Map every source onto its fixed slot
  always_comb begin
    req_vec = '0;
    lvl_vec = '0;
    // Slots 0,1 stay idle for reset overlays; unlisted slots stay reserved
    req_vec[0] = 1'b0;
    req_vec[1] = 1'b0;
    req_vec[`VIPT_V_ILLEGAL] = core_req.illegal;
    req_vec[`VIPT_V_SWI3] = core_req.swi3;
    req_vec[`VIPT_V_STACK_OVF] = core_req.stack_ovf;
    req_vec[`VIPT_V_MISALIGN] = core_req.misalign;
    lvl_vec[`VIPT_V_ILLEGAL] = `VIPT_LVL_3;
    lvl_vec[`VIPT_V_SWI3] = `VIPT_LVL_3;
    lvl_vec[`VIPT_V_STACK_OVF] = `VIPT_LVL_3;
    lvl_vec[`VIPT_V_MISALIGN] = `VIPT_LVL_3;
    // Debug port, level 1..3
    req_vec[`VIPT_V_DBG_STEP] = dbg_req.req[0];
    req_vec[`VIPT_V_DBG_BKPT0] = dbg_req.req[1];
    req_vec[`VIPT_V_DBG_TRACE] = dbg_req.req[2];
    req_vec[`VIPT_V_DBG_TX_EMPTY] = dbg_req.req[3];
    req_vec[`VIPT_V_DBG_RX_FULL] = dbg_req.req[4];
    lvl_vec[`VIPT_V_DBG_STEP] = clamp_lvl(dbg_req.lvl[0], `VIPT_LVL_1, `VIPT_LVL_3);
    lvl_vec[`VIPT_V_DBG_BKPT0] = clamp_lvl(dbg_req.lvl[1], `VIPT_LVL_1, `VIPT_LVL_3);
    lvl_vec[`VIPT_V_DBG_TRACE] = clamp_lvl(dbg_req.lvl[2], `VIPT_LVL_1, `VIPT_LVL_3);
    lvl_vec[`VIPT_V_DBG_TX_EMPTY] = clamp_lvl(dbg_req.lvl[3], `VIPT_LVL_1, `VIPT_LVL_3);
    lvl_vec[`VIPT_V_DBG_RX_FULL] = clamp_lvl(dbg_req.lvl[4], `VIPT_LVL_1, `VIPT_LVL_3);
    // Software interrupts at fixed levels
    req_vec[`VIPT_V_SWI2] = core_req.swi2;
    req_vec[`VIPT_V_SWI1] = core_req.swi1;
    req_vec[`VIPT_V_SWI0] = core_req.swi0;
    lvl_vec[`VIPT_V_SWI2] = `VIPT_LVL_2;
    lvl_vec[`VIPT_V_SWI1] = `VIPT_LVL_1;
    lvl_vec[`VIPT_V_SWI0] = `VIPT_LVL_0;
    // External requests and power/clock/flash
    req_vec[`VIPT_V_EXT_A] = per_req.req[0];
    req_vec[`VIPT_V_EXT_B] = per_req.req[1];
    req_vec[`VIPT_V_LVD] = per_req.req[2];
    req_vec[`VIPT_V_PLL] = per_req.req[3];
    req_vec[`VIPT_V_FLASH_ERR] = per_req.req[4];
    req_vec[`VIPT_V_FLASH_DONE] = per_req.req[5];
    req_vec[`VIPT_V_FLASH_EMPTY] = per_req.req[6];
    lvl_vec[`VIPT_V_EXT_A] = clamp_lvl(per_req.lvl[0], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_EXT_B] = clamp_lvl(per_req.lvl[1], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_LVD] = clamp_lvl(per_req.lvl[2], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_PLL] = clamp_lvl(per_req.lvl[3], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_FLASH_ERR] = clamp_lvl(per_req.lvl[4], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_FLASH_DONE] = clamp_lvl(per_req.lvl[5], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_FLASH_EMPTY] = clamp_lvl(per_req.lvl[6], `VIPT_LVL_0, `VIPT_LVL_2);
    // CAN, GPIO F..A, SPI1 then SPI0 (contiguous runs)
    for (int k = 0; k < 4; k++) begin
      req_vec[`VIPT_V_CAN_BASE + k] = per_req.req[7 + k];
      lvl_vec[`VIPT_V_CAN_BASE + k] = clamp_lvl(per_req.lvl[7 + k], `VIPT_LVL_0, `VIPT_LVL_2);
    end
    for (int k = 0; k < 6; k++) begin
      req_vec[`VIPT_V_GPIO_BASE + k] = per_req.req[11 + k];
      lvl_vec[`VIPT_V_GPIO_BASE + k] = clamp_lvl(per_req.lvl[11 + k], `VIPT_LVL_0, `VIPT_LVL_2);
    end
    for (int k = 0; k < 4; k++) begin
      req_vec[`VIPT_V_SPI1_BASE + k] = per_req.req[17 + k];
      lvl_vec[`VIPT_V_SPI1_BASE + k] = clamp_lvl(per_req.lvl[17 + k], `VIPT_LVL_0, `VIPT_LVL_2);
    end
    // Async serial unit 1, slot 44 left reserved
    req_vec[`VIPT_V_ASU1_TX_EMPTY] = per_req.req[21];
    req_vec[`VIPT_V_ASU1_TX_IDLE] = per_req.req[22];
    req_vec[`VIPT_V_ASU1_RX_ERR] = per_req.req[23];
    req_vec[`VIPT_V_ASU1_RX_FULL] = per_req.req[24];
    lvl_vec[`VIPT_V_ASU1_TX_EMPTY] = clamp_lvl(per_req.lvl[21], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_ASU1_TX_IDLE] = clamp_lvl(per_req.lvl[22], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_ASU1_RX_ERR] = clamp_lvl(per_req.lvl[23], `VIPT_LVL_0, `VIPT_LVL_2);
    lvl_vec[`VIPT_V_ASU1_RX_FULL] = clamp_lvl(per_req.lvl[24], `VIPT_LVL_0, `VIPT_LVL_2);
  end

  // Priority resolution
  vipt_resolve #(
    .NUM_VEC(`VIPT_NUM_VEC)
  ) u_resolve (
    .req(req_vec),
    .lvl(lvl_vec),
    .found(found),
    .win_lvl(win_lvl),
    .win_vec(win_vec)
  );

  // Next registered grant
  always_comb begin
    state_next = state_reg;
    state_next.grant.valid = found;
    state_next.grant.level = found ? win_lvl : `VIPT_LVL_0;
    state_next.grant.vector = found ? win_vec : 6'h00;
    state_next.grant.address = found ? vec_addr(vector_base_register, win_vec)
                                     : vector_base_register;
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign grant = state_reg.grant;
endmodule : vipt_table
`default_nettype wire

// >>> tb/vipt_table_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module vipt_table_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Observed ports
  input wire logic [18:0] vector_base_register,
  input wire vipt_pkg::vipt_core_s core_req,
  input wire vipt_pkg::vipt_dbg_s dbg_req,
  input wire vipt_pkg::vipt_periph_s per_req,
  input wire vipt_pkg::vipt_grant_s grant
);
  import vipt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Grant follows the previous edge's inputs
  addr_from_base_a: assert property (
    $past(rstn) |-> grant.address == $past(vector_base_register) + {grant.vector, 1'b0})
    else $error("grant address not base plus twice vector");
  core_level3_a: assert property (
    $past(rstn && core_req[6:3] != 4'h0) |-> grant.valid && grant.level == 2'h3)
    else $error("core exception not at level 3");
  illegal_first_a: assert property (
    $past(rstn && core_req.illegal) |-> grant.vector == 6'h02)
    else $error("illegal instruction not granted first");
  idle_zero_a: assert property (
    $past(rstn && core_req == '0 && dbg_req.req == '0 && per_req.req == '0)
    |-> !grant.valid && grant.vector == 6'h00 && grant.level == 2'h0)
    else $error("grant without request");
  no_reserved_a: assert property (
    grant.valid |-> !(grant.vector inside {0, 1, 8, 12, 13, 19, 25, 36, 37, 44}))
    else $error("reserved vector granted");
  serial_last_a: assert property (
    $past(rstn && core_req == '0 && dbg_req.req == '0 && per_req.req == 25'h100_0000)
    |-> grant.vector == 6'h2E && grant.level ==
      ($past(per_req.lvl[24]) == 2'h3 ? 2'h2 : $past(per_req.lvl[24])))
    else $error("serial receive full wrong");
  debug_level_a: assert property (
    $past(rstn && dbg_req.req != 5'h00) |-> grant.valid && grant.level != 2'h0)
    else $error("debug request below level 1");
  periph_only_a: assert property (
    $past(rstn && core_req == '0 && dbg_req.req == '0 && per_req.req != '0)
    |-> grant.valid && grant.level != 2'h3 && grant.vector >= 6'h11)
    else $error("peripheral grant out of range");
endmodule : vipt_table_chk
bind vipt_table vipt_table_chk chk_u (.clk(clk), .rstn(rstn),
  .vector_base_register(vector_base_register), .core_req(core_req),
  .dbg_req(dbg_req), .per_req(per_req), .grant(grant));
`default_nettype wire

// >>> tb/vipt_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vipt_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Grant from the table
  input wire vipt_pkg::vipt_grant_s grant,
  // Entry last fetched
  output logic [18:0] fetch_addr
);
  import vipt_pkg::*;
  // Fetch the entry of each pending grant
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_addr <= 19'h0_0000;
    end else if (grant.valid) begin
      fetch_addr <= grant.address;
    end
  end
endmodule : vipt_core_model
`default_nettype wire

// >>> tb/tb_vectored_interrupt_priority_table.sv
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_priority_table;
  import vipt_pkg::*;
  logic clk;
  logic rstn = 1'b0;
  logic [18:0] vector_base_register = 19'h4_0400;
  vipt_core_s core_req = '0;
  vipt_dbg_s dbg_req = '0;
  vipt_periph_s per_req = '0;
  vipt_grant_s grant;
  logic [18:0] fetch_addr;
  int num_errors = 0;
  int num_checks = 0;
  byte pv[25] = '{17, 18, 20, 21, 22, 23, 24, 26, 27, 28, 29, 30, 31, 32, 33, 34, 35,
    38, 39, 40, 41, 42, 43, 45, 46};
  byte dv[5] = '{6, 7, 9, 10, 11};
  byte cv[7] = '{16, 15, 14, 5, 4, 3, 2};
  vipt_table dut_u (.clk(clk), .rstn(rstn), .vector_base_register(vector_base_register),
    .core_req(core_req), .dbg_req(dbg_req), .per_req(per_req), .grant(grant));
  vipt_core_model core_u (.clk(clk), .rstn(rstn), .grant(grant), .fetch_addr(fetch_addr));
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare one value
  task automatic chk_val(input string what, input logic [27:0] e, input logic [27:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk_val
  // Grant one edge after inputs
  task automatic chk(input string what, input logic [1:0] lvl, input logic [5:0] vec);
    vipt_grant_s e;
    e.valid = vec != 6'h00;
    e.level = lvl;
    e.vector = vec;
    e.address = vector_base_register + {12'h000, vec, 1'b0};
    @(negedge clk);
    chk_val(what, e, grant);
  endtask : chk
  // Lone sources, every slot
  task automatic sweep_case();
    for (int i = 0; i < 25; i++) begin
      per_req.req = 25'h1 << i;
      per_req.lvl[i] = 2'(i % 4);
      chk("periph", (i % 4 == 3) ? 2'h2 : 2'(i % 4), 6'(pv[i]));
    end
    per_req = '0;
    for (int i = 0; i < 5; i++) begin
      dbg_req.req = 5'h1 << i;
      dbg_req.lvl[i] = 2'(i % 4);
      chk("debug", (i % 4 == 0) ? 2'h1 : 2'(i % 4), 6'(dv[i]));
    end
    dbg_req = '0;
    for (int i = 0; i < 7; i++) begin
      core_req = vipt_core_s'(7'h01 << i);
      chk("core", (i > 2) ? 2'h3 : 2'(i), 6'(cv[i]));
    end
    core_req = '0;
    chk("idle", 2'h0, 6'h00);
  endtask : sweep_case
  // Level first, then lowest vector
  task automatic order_case();
    per_req.req[0] = 1'b1;
    per_req.lvl[0] = 2'h1;
    per_req.req[16] = 1'b1;
    per_req.lvl[16] = 2'h1;
    chk("tie", 2'h1, 6'h11);
    per_req.lvl[16] = 2'h3;
    chk("higher", 2'h2, 6'h23);
    dbg_req.req[4] = 1'b1;
    chk("debug low", 2'h2, 6'h23);
    dbg_req.lvl[4] = 2'h3;
    chk("debug top", 2'h3, 6'h0B);
    core_req.swi3 = 1'b1;
    chk("swi3", 2'h3, 6'h03);
    dbg_req = '0;
    core_req = '0;
    per_req = '0;
  endtask : order_case
  // Base moves, address wraps, reset mid-run
  task automatic base_case();
    vector_base_register = 19'h7_FFFC;
    per_req.req[2] = 1'b1;
    per_req.lvl[2] = 2'h2;
    chk("lvd", 2'h2, 6'h14);
    core_req.illegal = 1'b1;
    chk("illegal", 2'h3, 6'h02);
    @(negedge clk);
    chk_val("fetch", 28'h000_0000, {9'h000, fetch_addr});
    rstn = 1'b0;
    @(negedge clk);
    chk_val("reset", 28'h000_0000, grant);
    rstn = 1'b1;
    chk("after reset", 2'h3, 6'h02);
    core_req = '0;
    per_req = '0;
  endtask : base_case
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Hang guard, well past the run
  initial begin
    #(40 * 2000);
    num_errors++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    sweep_case();
    order_case();
    base_case();
    final_report();
  end
endmodule : tb_vectored_interrupt_priority_table
`default_nettype wire
